// ===== common/metering_pkg.sv
package metering_pkg;
    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int REG_W = 16;

    // register indices; byte address is four times the index
    localparam logic [15:0] COMPUTATION_MODE_CONFIG_INDEX = 16'hE600;
    localparam logic [15:0] GAIN_INDEX = 16'hE60F;
    localparam logic [ADDR_W-3:0] COMPUTATION_MODE_CONFIG_WORD = {2'h0, COMPUTATION_MODE_CONFIG_INDEX};
    localparam logic [ADDR_W-3:0] GAIN_WORD = {2'h0, GAIN_INDEX};

    // ------------------------------------------------------------------
    // computation-mode fields (bit 15 is not stored)
    // ------------------------------------------------------------------
    localparam int CM_STORE_W = 15;
    localparam int PULSE3_C_BIT = 8;
    localparam int ANGLE_LSB = 9;
    localparam int ANGLE_W = 2;
    localparam int NOMV_A_BIT = 11;
    localparam int NOMV_B_BIT = 12;
    localparam int NOMV_C_BIT = 13;
    localparam int FREQ_BIT = 14;
    localparam logic [CM_STORE_W-1:0] COMPUTATION_MODE_CONFIG_RESET = 15'h01FF;

    // ------------------------------------------------------------------
    // gain fields (bits 15:9 are not stored)
    // ------------------------------------------------------------------
    localparam int GAIN_STORE_W = 9;
    localparam int GAIN_FIELD_W = 3;
    localparam int PGA_PHASE_I_LSB = 0;
    localparam int PGA_NEUTRAL_LSB = 3;
    localparam int PGA_PHASE_V_LSB = 6;
    localparam logic [GAIN_STORE_W-1:0] GAIN_RESET = 9'h000;
    localparam logic [GAIN_FIELD_W-1:0] GAIN_CODE_MAX = 3'h4;
    localparam logic [GAIN_FIELD_W-1:0] GAIN_UNITY = 3'h0;

    // channels handled by the gain decoder
    localparam int NUM_CHAN = 3;
    localparam int CHAN_PHASE_I = 0;
    localparam int CHAN_NEUTRAL = 1;
    localparam int CHAN_PHASE_V = 2;

    // ------------------------------------------------------------------
    // bus responses and enumerations
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ANGLE_VOLT_CURR,
        ANGLE_VOLT_VOLT,
        ANGLE_CURR_CURR,
        ANGLE_NONE
    } angle_mode_t;

    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_COMPUTATION_MODE_CONFIG,
        SEL_GAIN
    } reg_sel_t;
endpackage : metering_pkg

// ===== common/gain_if.sv
// ----------------------------------------------------------------------
// gain codes out to the decoder, shift amounts back
// ----------------------------------------------------------------------
interface gain_if;
    import metering_pkg::*;
    logic [NUM_CHAN-1:0][GAIN_FIELD_W-1:0] code;
    logic [NUM_CHAN-1:0][GAIN_FIELD_W-1:0] shift;

    modport regs (output code, input shift);
    modport decoder (input code, output shift);
endinterface : gain_if

// ===== hdl/gain_decode.sv
module gain_decode (
    gain_if.decoder gains
);
    import metering_pkg::*;

    // ------------------------------------------------------------------
    // code to shift mapping
    // ------------------------------------------------------------------
    // gain is 1 shl shift; reserved codes fall back to unity so a bad
    // write can never saturate the front end
    function automatic logic [GAIN_FIELD_W-1:0] code_to_shift(
        input logic [GAIN_FIELD_W-1:0] code
    );
        if (code <= GAIN_CODE_MAX) begin
            code_to_shift = code;
        end else begin
            code_to_shift = GAIN_UNITY;
        end
    endfunction : code_to_shift

    // one decoder per channel, all with the same mapping
    for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
        assign gains.shift[i] = code_to_shift(gains.code[i]);
    end
endmodule : gain_decode

// ===== hdl/metering_config_gain_regs.sv
module metering_config_gain_regs #(
    parameter bit has_neutral_channel = 1'b1,
    parameter bit has_fundamental = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // write address channel
    input wire logic awvalid,
    output logic awready,
    input wire logic [metering_pkg::ADDR_W-1:0] awaddr,
    // write data channel
    input wire logic wvalid,
    output logic wready,
    input wire logic [metering_pkg::DATA_W-1:0] wdata,
    input wire logic [metering_pkg::STRB_W-1:0] wstrb,
    // write response channel
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // read address channel
    input wire logic arvalid,
    output logic arready,
    input wire logic [metering_pkg::ADDR_W-1:0] araddr,
    // read data channel
    output logic rvalid,
    input wire logic rready,
    output logic [metering_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // decoded selections toward the measurement datapath
    output logic pulse3_phase_c_include,
    output metering_pkg::angle_mode_t angle_measure_select,
    output logic phase_a_nominal_volt_use,
    output logic phase_b_nominal_volt_use,
    output logic phase_c_nominal_volt_use,
    output logic line_frequency_select,
    output logic [metering_pkg::GAIN_FIELD_W-1:0] phase_current_gain,
    output logic [metering_pkg::GAIN_FIELD_W-1:0] neutral_current_gain,
    output logic [metering_pkg::GAIN_FIELD_W-1:0] phase_voltage_gain
);
    import metering_pkg::*;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // word address decode, shared by the write and the read path
    function automatic reg_sel_t reg_select(
        input logic [ADDR_W-1:0] addr
    );
        if (addr[ADDR_W-1:2] == COMPUTATION_MODE_CONFIG_WORD) begin
            reg_select = SEL_COMPUTATION_MODE_CONFIG;
        end else if (addr[ADDR_W-1:2] == GAIN_WORD) begin
            reg_select = SEL_GAIN;
        end else begin
            reg_select = SEL_NONE;
        end
    endfunction : reg_select

    // merge the two low byte lanes into a 16-bit register image
    function automatic logic [REG_W-1:0] apply_strb(
        input logic [REG_W-1:0] old_val,
        input logic [DATA_W-1:0] new_val,
        input logic [STRB_W-1:0] strb
    );
        logic [REG_W-1:0] merged;
        merged = old_val;
        if (strb[0]) begin
            merged[7:0] = new_val[7:0];
        end
        if (strb[1]) begin
            merged[15:8] = new_val[15:8];
        end
        apply_strb = merged;
    endfunction : apply_strb

    // ------------------------------------------------------------------
    // storage and bus state
    // ------------------------------------------------------------------
    logic [CM_STORE_W-1:0] computation_mode_config;
    logic [GAIN_STORE_W-1:0] gain;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [DATA_W-1:0] w_data_q;
    logic [STRB_W-1:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;
    logic do_write;
    reg_sel_t wsel;
    reg_sel_t rsel;
    logic [REG_W-1:0] computation_mode_config_image;
    logic [REG_W-1:0] gain_image;
    logic [REG_W-1:0] next_computation_mode_config;
    logic [REG_W-1:0] next_gain;

    gain_if gains ();

    // ------------------------------------------------------------------
    // handshake outputs
    // ------------------------------------------------------------------
    // no new write is taken while a response waits, so only one write
    // is ever in flight; ce low drops awready, wready and arready but leaves bvalid and rvalid
    assign awready = ce && !aw_held && !bvalid_q;
    assign wready = ce && !w_held && !bvalid_q;
    assign arready = ce && !rvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // commit once both halves of a write are held
    assign do_write = aw_held && w_held && !bvalid_q;
    assign wsel = reg_select(aw_addr_q);
    assign rsel = reg_select(araddr);

    // ------------------------------------------------------------------
    // register images and write merge
    // ------------------------------------------------------------------
    // unstored upper bits read as zero whatever was written
    assign computation_mode_config_image = {1'b0, computation_mode_config};
    assign gain_image = {7'h00, gain};
    assign next_computation_mode_config = apply_strb(computation_mode_config_image, w_data_q, w_strb_q);
    assign next_gain = apply_strb(gain_image, w_data_q, w_strb_q);

    // ------------------------------------------------------------------
    // write address capture
    // ------------------------------------------------------------------
    // address and data may arrive in either order, each is held alone
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr_q <= '0;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr_q <= awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // write data capture
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (ce) begin
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // write response
    // ------------------------------------------------------------------
    // unmapped addresses complete with an error and change nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // computation-mode register
    // ------------------------------------------------------------------
    // low bits are kept so read-back matches; only 14:8 steer logic here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            computation_mode_config <= COMPUTATION_MODE_CONFIG_RESET;
        end else if (ce && do_write && wsel == SEL_COMPUTATION_MODE_CONFIG) begin
            computation_mode_config <= next_computation_mode_config[CM_STORE_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // gain register
    // ------------------------------------------------------------------
    // without a neutral input the neutral field is pinned to unity
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gain <= GAIN_RESET;
        end else if (ce && do_write && wsel == SEL_GAIN) begin
            gain <= next_gain[GAIN_STORE_W-1:0];
            if (!has_neutral_channel) begin
                gain[PGA_NEUTRAL_LSB +: GAIN_FIELD_W] <= GAIN_UNITY;
            end
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // data answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                rvalid_q <= 1'b1;
                case (rsel)
                    SEL_COMPUTATION_MODE_CONFIG: begin
                        rdata_q <= {16'h0000, computation_mode_config_image};
                        rresp_q <= RESP_OKAY;
                    end
                    SEL_GAIN: begin
                        rdata_q <= {16'h0000, gain_image};
                        rresp_q <= RESP_OKAY;
                    end
                    default: begin
                        rdata_q <= '0;
                        rresp_q <= RESP_SLVERR;
                    end
                endcase
            end else if (rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // gain decode
    // ------------------------------------------------------------------
    assign gains.code[CHAN_PHASE_I] = gain[PGA_PHASE_I_LSB +: GAIN_FIELD_W];
    assign gains.code[CHAN_NEUTRAL] = gain[PGA_NEUTRAL_LSB +: GAIN_FIELD_W];
    assign gains.code[CHAN_PHASE_V] = gain[PGA_PHASE_V_LSB +: GAIN_FIELD_W];

    gain_decode u_gain_decode (
        .gains(gains)
    );

    // ------------------------------------------------------------------
    // gain outputs
    // ------------------------------------------------------------------
    // registered so the datapath sees clean levels; one cycle behind
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_current_gain <= GAIN_UNITY;
            neutral_current_gain <= GAIN_UNITY;
            phase_voltage_gain <= GAIN_UNITY;
        end else if (ce) begin
            phase_current_gain <= gains.shift[CHAN_PHASE_I];
            neutral_current_gain <= gains.shift[CHAN_NEUTRAL];
            phase_voltage_gain <= gains.shift[CHAN_PHASE_V];
        end
    end

    // ------------------------------------------------------------------
    // angle selection
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            angle_measure_select <= ANGLE_VOLT_CURR;
        end else if (ce) begin
            case (computation_mode_config[ANGLE_LSB +: ANGLE_W])
                2'h0: angle_measure_select <= ANGLE_VOLT_CURR;
                2'h1: angle_measure_select <= ANGLE_VOLT_VOLT;
                2'h2: angle_measure_select <= ANGLE_CURR_CURR;
                default: angle_measure_select <= ANGLE_NONE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pulse, nominal voltage and frequency selections
    // ------------------------------------------------------------------
    // line frequency only matters on parts that compute fundamentals;
    // elsewhere it is held low so the datapath ignores it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse3_phase_c_include <= COMPUTATION_MODE_CONFIG_RESET[PULSE3_C_BIT];
            phase_a_nominal_volt_use <= 1'b0;
            phase_b_nominal_volt_use <= 1'b0;
            phase_c_nominal_volt_use <= 1'b0;
            line_frequency_select <= 1'b0;
        end else if (ce) begin
            pulse3_phase_c_include <= computation_mode_config[PULSE3_C_BIT];
            phase_a_nominal_volt_use <= computation_mode_config[NOMV_A_BIT];
            phase_b_nominal_volt_use <= computation_mode_config[NOMV_B_BIT];
            phase_c_nominal_volt_use <= computation_mode_config[NOMV_C_BIT];
            line_frequency_select <= has_fundamental && computation_mode_config[FREQ_BIT];
        end
    end
endmodule : metering_config_gain_regs

// ===== verification/metering_config_gain_regs_properties.sv
// ----------------------------------------------------------------------
// bus handshake and selection checks
// ----------------------------------------------------------------------
module cfg_regs_checker (
    input logic aclk,
    input logic aresetn,
    input logic ce,
    input logic awvalid,
    input logic awready,
    input logic wvalid,
    input logic wready,
    input logic bvalid,
    input logic bready,
    input logic [1:0] bresp,
    input logic arvalid,
    input logic arready,
    input logic rvalid,
    input logic rready,
    input logic [metering_pkg::DATA_W-1:0] rdata,
    input logic pulse3_phase_c_include,
    input logic [metering_pkg::GAIN_FIELD_W-1:0] phase_current_gain,
    input logic [metering_pkg::GAIN_FIELD_W-1:0] neutral_current_gain,
    input logic [metering_pkg::GAIN_FIELD_W-1:0] phase_voltage_gain
);
    import metering_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // both write halves taken on one edge
    sequence s_write;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_read;
        arvalid && arready;
    endsequence
    property p_write_answer;
        s_write |-> ##2 bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write response late");
    property p_read_answer;
        s_read |=> rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read data late");
    property p_b_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped");
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped");
    property p_ce_freeze;
        !ce |-> !awready && !wready && !arready;
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("ready while clock enable low");
    // reserved codes must never reach the datapath as shifts above four
    property p_phase_i_range;
        phase_current_gain <= GAIN_CODE_MAX;
    endproperty
    a_phase_i_range: assert property (p_phase_i_range)
        else $error("phase current shift out of range");
    property p_neutral_range;
        neutral_current_gain <= GAIN_CODE_MAX;
    endproperty
    a_neutral_range: assert property (p_neutral_range)
        else $error("neutral shift out of range");
    property p_phase_v_range;
        phase_voltage_gain <= GAIN_CODE_MAX;
    endproperty
    a_phase_v_range: assert property (p_phase_v_range)
        else $error("voltage shift out of range");
    // selections move only after a write lands or a reset ends
    property p_sel_cause;
        $changed({pulse3_phase_c_include, phase_current_gain,
            neutral_current_gain, phase_voltage_gain})
            |-> $past(bvalid) || !$past(aresetn);
    endproperty
    a_sel_cause: assert property (p_sel_cause)
        else $error("selection changed without a write");
endmodule : cfg_regs_checker

bind metering_config_gain_regs cfg_regs_checker chk (
    .aclk, .aresetn, .ce, .awvalid, .awready, .wvalid, .wready,
    .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready,
    .rdata, .pulse3_phase_c_include, .phase_current_gain,
    .neutral_current_gain, .phase_voltage_gain
);

// ===== verification/metering_config_gain_regs_tb_top.sv
module metering_config_gain_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import metering_pkg::*;
    // ------------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CA = {COMPUTATION_MODE_CONFIG_WORD, 2'b00};
    localparam logic [ADDR_W-1:0] GA = {GAIN_WORD, 2'b00};
    typedef struct {
        logic [ADDR_W-1:0] a;
        logic [15:0] d;
        logic [15:0] rb;
        logic [15:0] ob;
    } row_t;
    // address, data written, readback, decoded selections
    row_t rows[8] = '{
        '{GA, 16'hFFFF, 16'h01FF, 16'h8000},
        '{GA, 16'h0123, 16'h0123, 16'h80E4},
        '{GA, 16'h0151, 16'h0151, 16'h8050},
        '{GA, 16'h00A2, 16'h00A2, 16'h80A2},
        '{CA, 16'hFFFF, 16'h7FFF, 16'hFEA2},
        '{CA, 16'h2A00, 16'h2A00, 16'h34A2},
        '{CA, 16'h4500, 16'h4500, 16'hC2A2},
        '{CA, 16'h1000, 16'h1000, 16'h08A2}
    };
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata, rdv;
    logic [STRB_W-1:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    logic p3, fa, fb, fc, fq;
    angle_mode_t ang;
    logic [GAIN_FIELD_W-1:0] gi, gn, gv;
    wire [15:0] obs = {p3, ang, fa, fb, fc, fq, gi, gn, gv};
    int miscompares = 0;
    int n_compared = 0;

    // 25 MHz core clock
    always #20 aclk = ~aclk;

    metering_config_gain_regs uut (
        .aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .wvalid,
        .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .pulse3_phase_c_include(p3), .angle_measure_select(ang),
        .phase_a_nominal_volt_use(fa), .phase_b_nominal_volt_use(fb),
        .phase_c_nominal_volt_use(fc), .line_frequency_select(fq),
        .phase_current_gain(gi), .neutral_current_gain(gn),
        .phase_voltage_gain(gv)
    );

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_resp

    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // a wait that ran out counts as a mismatch and ends the run
    task automatic bounded(input bit done);
        if (!done) begin
            chk_val(32'h0, 32'h1);
            end_of_test();
        end
    endtask : bounded

    // sampled at the falling edge so the handshake seen is settled;
    // one idle edge first so a ready never drops and rises in one step
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d,
        input logic [3:0] s, output logic [1:0] r);
        bit done, ta, tw;
        @(posedge aclk);
        done = 1'b0;
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 40 && !done; i++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            done = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            bready <= !done;
        end
        bounded(done);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
        output logic [1:0] r);
        bit done, ta;
        @(posedge aclk);
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 40 && !done; i++) begin
            @(negedge aclk);
            ta = arvalid && arready;
            done = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            rready <= !done;
        end
        bounded(done);
    endtask : rd

    task automatic chk_defaults();
        rd(CA, rdv, rsp);
        chk_val(rdv, 32'h0000_01FF);
        rd(GA, rdv, rsp);
        chk_val(rdv, 32'h0000_0000);
        chk_val({16'h0000, obs}, 32'h0000_8000);
    endtask : chk_defaults

    // table first, then the awkward cases by hand
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        chk_defaults();
        $display("reset defaults done");
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].d, 4'hF, rsp);
            chk_resp(rsp, RESP_OKAY);
            rd(rows[k].a, rdv, rsp);
            chk_val(rdv, {16'h0000, rows[k].rb});
            chk_val({16'h0000, obs}, {16'h0000, rows[k].ob});
            chk_val({31'h0, fq}, {31'h0, rows[k].ob[9]});
            $display("row %0d done", k);
        end
        wr(CA + 20'h4, 16'hFFFF, 4'hF, rsp);
        chk_resp(rsp, RESP_SLVERR);
        rd(CA + 20'h4, rdv, rsp);
        chk_resp(rsp, RESP_SLVERR);
        chk_val(rdv, 32'h0000_0000);
        $display("unmapped access done");
        wr(GA, 16'h01FF, 4'h2, rsp);
        rd(GA, rdv, rsp);
        chk_val(rdv, 32'h0000_01A2);
        chk_val({16'h0000, obs}, 32'h0000_08A0);
        $display("upper lane write done");
        // slow master: both answers must stand until they are accepted
        awaddr <= GA;
        wdata <= 32'h0000_01A2;
        wstrb <= 4'h3;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        araddr <= GA;
        arvalid <= 1'b1;
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        arvalid <= 1'b0;
        repeat (3) @(posedge aclk);
        chk_val({31'h0, bvalid}, 32'h1);
        chk_resp(bresp, RESP_OKAY);
        chk_val({31'h0, rvalid}, 32'h1);
        chk_val(rdata, 32'h0000_01A2);
        bready <= 1'b1;
        rready <= 1'b1;
        @(posedge aclk);
        bready <= 1'b0;
        rready <= 1'b0;
        $display("stalled answer done");
        ce <= 1'b0;
        repeat (4) @(posedge aclk);
        chk_val({31'h0, awready}, 32'h0);
        ce <= 1'b1;
        rd(GA, rdv, rsp);
        chk_val(rdv, 32'h0000_01A2);
        $display("clock enable pause done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk_defaults();
        $display("second reset done");
        end_of_test();
    end
endmodule : metering_config_gain_regs_tb_top
